// file: core/embi_pkg.sv
// Behaviour
// - Fetch strobe pulses once per six-clock machine slot in external fetch, not during data.
// - Fetch strobe stays high while code runs from internal memory.
// - Fetch strobe pulled low at reset release selects serial download mode.
// - Address latch strobe pulses every external fetch slot to latch the low address byte, skipped during data access.
// - With external access select high, addresses 0000H-1FFFH fetch internally.
// - With external access select low, every fetch goes to external memory.
// - Low byte bus port multiplexes low address and data bytes.
// - Bus ones on the low byte port are driven strongly, not left open.
// - Low byte port as general port is open-drain; written ones float.
// - High byte port carries high address, or middle and high for 24-bit data.
// - High byte port general bits written one are pulled up and usable as inputs.
// - Data store strobe asserted for writes; memory latches low port byte on it.
// - Data read strobe asserted for reads; memory drives low port during it.
// - Reset input held high 24 clock cycles resets the device.
package embi_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int          SLOT_CLKS      = 6;
  localparam int          RESET_HOLD     = 24;
  localparam logic [2:0]  PH_ALE_HI      = 3'h0;
  localparam logic [2:0]  PH_ALE_LO      = 3'h2;
  localparam logic [2:0]  PH_STB_LO      = 3'h3;
  localparam logic [2:0]  PH_LAST        = 3'h5;

  // ---------------------------------------------------------------------------
  // Address map and values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] INT_CODE_TOP   = 16'h1FFF;
  localparam logic [7:0]  PORT_RESET     = 8'hFF;
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;

  typedef enum logic [1:0] {EMBI_IDLE, EMBI_FETCH, EMBI_RD, EMBI_WR} embi_cycle_t;

endpackage : embi_pkg

// file: core/embi_rst_filter.sv
`timescale 1ns/100ps
`default_nettype none
module embi_rst_filter
  import embi_pkg::*;
(
  // Clock and pin
  input  wire logic clk,
  input  wire logic reset_pin,
  // Filtered reset request
  output var  logic rst_req
);

  logic [4:0] cnt;

  // Count consecutive high samples; a short glitch never resets the core.
  always_ff @(posedge clk) begin
    if (!reset_pin) begin
      cnt     <= 5'h00;
      rst_req <= 1'b0;
    end else if (cnt >= 5'(RESET_HOLD - 1)) begin
      rst_req <= 1'b1;
    end else begin
      cnt <= cnt + 5'h01;
    end
  end

endmodule : embi_rst_filter
`default_nettype wire

// file: core/embi_top.sv
`timescale 1ns/100ps
`default_nettype none
module embi_top
  import embi_pkg::*;
(
  // Clock and resets
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        reset_pin,
  // Core side
  input  wire logic [15:0] pc,
  input  wire logic        fetch_req,
  input  wire logic        rd_req,
  input  wire logic        wr_req,
  input  wire logic [23:0] data_addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic [7:0]  p0_latch,
  input  wire logic [7:0]  p2_latch,
  output logic             op_done,
  output logic [7:0]       op_data,
  output logic             op_internal,
  output logic             core_reset,
  output logic             download_mode,
  // Pins
  input  wire logic        external_access_select,
  input  wire logic        program_fetch_strobe_in,
  output logic             program_fetch_strobe_n,
  output logic             addr_latch_strobe,
  output logic             data_read_strobe_n,
  output logic             data_store_strobe_n,
  input  wire logic [7:0]  low_byte_bus_port_in,
  output logic [7:0]       low_byte_bus_port_out,
  output logic [7:0]       low_byte_bus_port_oe,
  output logic [7:0]       high_byte_port_out,
  output logic [7:0]       high_byte_port_oe
);

  // ---------------------------------------------------------------------------
  // Reset filter
  // ---------------------------------------------------------------------------
  logic rst_req;
  logic rst_req_d;

  embi_rst_filter embi_rst_filter_inst (
    .clk       (clk),
    .reset_pin (reset_pin),
    .rst_req   (rst_req)
  );

  // Core reset follows the filtered pin; strap is caught as it releases.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_req_d     <= 1'b1;
      core_reset    <= 1'b1;
      download_mode <= 1'b0;
    end else begin
      rst_req_d  <= rst_req;
      core_reset <= rst_req;
      if (rst_req_d && !rst_req) begin
        download_mode <= !program_fetch_strobe_in;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Machine slot sequencer
  // ---------------------------------------------------------------------------
  embi_cycle_t cyc;
  embi_cycle_t next_cyc;
  logic [2:0]  phase;
  logic [23:0] addr;
  logic [7:0]  wdat;
  logic        slot_free;
  logic        take_data;
  logic        take_fetch;

  // Decide whether a code address is served from internal memory.
  function automatic logic is_internal(input logic ea, input logic [15:0] a);
    is_internal = ea && (a <= INT_CODE_TOP);
  endfunction : is_internal

  // True in the phases that put an address on the ports.
  function automatic logic addr_phase(input logic [2:0] ph);
    addr_phase = (ph < PH_ALE_LO);
  endfunction : addr_phase

  // True in the phases in which a data strobe is held low.
  function automatic logic data_window(input logic [2:0] ph);
    data_window = (ph >= PH_ALE_LO) && (ph < PH_LAST);
  endfunction : data_window

  // A slot ends at its last phase; a filtered reset takes nothing new.
  assign slot_free  = !core_reset && ((cyc == EMBI_IDLE) || (phase == PH_LAST));
  assign take_data  = slot_free && (rd_req || wr_req);
  assign take_fetch = slot_free && !take_data && fetch_req;

  // Data wins over fetch and read over write; a running slot keeps its kind.
  always_comb begin
    if (take_data) begin
      next_cyc = rd_req ? EMBI_RD : EMBI_WR;
    end else if (take_fetch) begin
      next_cyc = EMBI_FETCH;
    end else if (slot_free) begin
      next_cyc = EMBI_IDLE;
    end else begin
      next_cyc = cyc;
    end
  end

  // Requests are taken only at a slot boundary, so strobes stay whole unless core_reset cuts the slot.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc   <= EMBI_IDLE;
      phase <= PH_ALE_HI;
    end else if (core_reset) begin
      cyc   <= EMBI_IDLE;
      phase <= PH_ALE_HI;
    end else if (slot_free) begin
      cyc   <= next_cyc;
      phase <= PH_ALE_HI;
    end else begin
      phase <= phase + 3'h1;
    end
  end

  // Address and write byte are held for the slot, so the core may move on.
  // An internal fetch drives no strobes, so op_internal also gates the pins.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr        <= 24'h000000;
      wdat        <= BYTE_ZERO;
      op_internal <= 1'b0;
    end else if (take_data) begin
      addr        <= data_addr;
      wdat        <= wr_data;
      op_internal <= 1'b0;
    end else if (take_fetch) begin
      addr        <= {BYTE_ZERO, pc};
      op_internal <= is_internal(external_access_select, pc);
    end
  end

  // Completion pulse and fetched or read byte; the byte is sampled in the
  // last phase, while the strobe pin is still low.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      op_done <= 1'b0;
      op_data <= BYTE_ZERO;
    end else begin
      op_done <= slot_free && (cyc != EMBI_IDLE);
      if (slot_free && (cyc != EMBI_IDLE) && (cyc != EMBI_WR) && !op_internal) begin
        op_data <= low_byte_bus_port_in;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Strobes
  // ---------------------------------------------------------------------------
  logic ext_fetch;
  logic data_cyc;
  assign ext_fetch = (cyc == EMBI_FETCH) && !op_internal;
  assign data_cyc  = (cyc == EMBI_RD) || (cyc == EMBI_WR);

  // Strobes are registered from the current phase so pins come from flops.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_latch_strobe      <= 1'b0;
      program_fetch_strobe_n <= 1'b1;
      data_read_strobe_n     <= 1'b1;
      data_store_strobe_n    <= 1'b1;
    end else begin
      // Latch pulse high in early phases; falling edge at PH_ALE_LO.
      addr_latch_strobe <= ext_fetch && addr_phase(phase) && !data_cyc;
      // Fetch strobe low late in slot, high when internal or data access.
      program_fetch_strobe_n <= !(ext_fetch && phase >= PH_STB_LO
                                  && phase < PH_LAST);
      data_read_strobe_n  <= !(cyc == EMBI_RD && data_window(phase));
      data_store_strobe_n <= !(cyc == EMBI_WR && data_window(phase));
    end
  end

  // ---------------------------------------------------------------------------
  // Port drivers
  // ---------------------------------------------------------------------------
  // Bus phases drive both levels; general mode only pulls low, ones float.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_byte_bus_port_out <= PORT_RESET;
      low_byte_bus_port_oe  <= BYTE_ZERO;
      high_byte_port_out    <= PORT_RESET;
      high_byte_port_oe     <= BYTE_ZERO;
    end else if (ext_fetch && addr_phase(phase)) begin
      low_byte_bus_port_out <= addr[7:0];
      low_byte_bus_port_oe  <= PORT_RESET;
      high_byte_port_out    <= addr[15:8];
      high_byte_port_oe     <= PORT_RESET;
    end else if (ext_fetch) begin
      low_byte_bus_port_oe  <= BYTE_ZERO;  // memory drives code byte
      high_byte_port_out    <= addr[15:8];
      high_byte_port_oe     <= PORT_RESET;
    end else if (data_cyc) begin
      // Data slot: low address then write data, or released for a read; page byte on high port first.
      high_byte_port_out <= addr_phase(phase) ? addr[23:16] : addr[15:8];
      high_byte_port_oe  <= PORT_RESET;
      if (addr_phase(phase)) begin
        low_byte_bus_port_out <= addr[7:0];
        low_byte_bus_port_oe  <= PORT_RESET;
      end else if (cyc == EMBI_WR) begin
        low_byte_bus_port_out <= wdat;
        low_byte_bus_port_oe  <= PORT_RESET;
      end else begin
        low_byte_bus_port_oe  <= BYTE_ZERO;
      end
    end else begin
      low_byte_bus_port_out <= BYTE_ZERO;
      low_byte_bus_port_oe  <= ~p0_latch;
      high_byte_port_out    <= p2_latch;
      high_byte_port_oe     <= ~p2_latch;  // ones left to the pull-up
    end
  end

endmodule : embi_top
`default_nettype wire

// file: sim/embi_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// External code and data memory with its address latch
// ------------------------------------------------------------
module embi_mem_model (
  // Clock and strobes
  input wire logic       clk,
  input wire logic       latch_stb,
  input wire logic       fetch_n,
  input wire logic       rd_n,
  input wire logic       st_n,
  // Buses
  input wire logic [7:0] bus,
  input wire logic [7:0] hi,
  output logic     [7:0] drv,
  // Page byte seen on the high port just before a data strobe
  output logic     [7:0] page
);
  logic [7:0] mem [256];
  logic [7:0] lo_addr;
  logic [7:0] last = 8'h00;
  // High port value at the edge before a data strobe falls is the page byte.
  always @(posedge clk) if (rd_n && st_n && fetch_n) page <= hi;
  // Last bus value seen while the latch strobe is high is what its fall keeps.
  always @(posedge clk) if (latch_stb) lo_addr <= bus;
  // Writes land on the high-port address; a floating bus shows a moving pattern.
  always @(posedge clk) begin
    if (!st_n) mem[hi] <= bus;
    last <= drv;
  end
  // Memory drives only while the fetch or read strobe is low.
  always_comb
    if (!fetch_n) drv = lo_addr ^ {hi[3:0], hi[7:4]};
    else if (!rd_n) drv = mem[hi];
    else drv = ~last;
endmodule : embi_mem_model
`default_nettype wire

// file: sim/embi_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Strobe and bus-turnaround checks on the top pins
// ------------------------------------------------------------
module embi_top_assertions (
  // Clock and reset
  input wire logic       clk,
  input wire logic       arst_n,
  // Watched pins
  input wire logic       op_internal,
  input wire logic       program_fetch_strobe_n,
  input wire logic       addr_latch_strobe,
  input wire logic       data_read_strobe_n,
  input wire logic       data_store_strobe_n,
  input wire logic [7:0] low_byte_bus_port_oe
);
  // One clock domain, so reset silences every check here.
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_fetch_lo;
    !program_fetch_strobe_n [*2] ##1 program_fetch_strobe_n;
  endsequence
  sequence s_data_lo(n);
    !n [*3] ##1 n;
  endsequence
  property p_fetch_pulse;
    $fell(program_fetch_strobe_n) |-> s_fetch_lo;
  endproperty
  a_fetch_pulse: assert property (p_fetch_pulse) else $error("fetch strobe width");
  property p_quiet_data;
    !data_read_strobe_n || !data_store_strobe_n |-> program_fetch_strobe_n && !addr_latch_strobe;
  endproperty
  a_quiet_data: assert property (p_quiet_data) else $error("strobe in data cycle");
  property p_internal;
    op_internal |-> program_fetch_strobe_n;
  endproperty
  a_internal: assert property (p_internal) else $error("fetch strobe on internal");
  property p_latch_pulse;
    $fell(addr_latch_strobe) |-> $past(addr_latch_strobe, 2);
  endproperty
  a_latch_pulse: assert property (p_latch_pulse) else $error("latch strobe width");
  property p_addr_drive;
    addr_latch_strobe |-> low_byte_bus_port_oe == 8'hFF;
  endproperty
  a_addr_drive: assert property (p_addr_drive) else $error("address not driven");
  property p_rd_pulse;
    $fell(data_read_strobe_n) |-> s_data_lo(data_read_strobe_n);
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe width");
  property p_release;
    !data_read_strobe_n || !program_fetch_strobe_n |-> low_byte_bus_port_oe == 8'h00;
  endproperty
  a_release: assert property (p_release) else $error("bus not released");
  property p_wr_pulse;
    $fell(data_store_strobe_n) |-> s_data_lo(data_store_strobe_n);
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("store strobe width");
  property p_wr_drive;
    !data_store_strobe_n |-> low_byte_bus_port_oe == 8'hFF;
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write data not driven");
endmodule : embi_top_assertions
bind embi_top embi_top_assertions embi_top_assertions_inst (.clk, .arst_n, .op_internal,
  .program_fetch_strobe_n, .addr_latch_strobe, .data_read_strobe_n, .data_store_strobe_n,
  .low_byte_bus_port_oe);
`default_nettype wire

// file: sim/tb_external_memory_bus_interface.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Random fetch, read and write traffic plus reset filtering
// ------------------------------------------------------------
module tb_external_memory_bus_interface import embi_pkg::*;;
  logic        clk, arst_n, reset_pin, fetch_req, rd_req, wr_req, ea, strap;
  logic        op_done, op_internal, core_reset, download_mode;
  logic        fetch_n, latch_stb, rd_n, st_n;
  logic [15:0] pc;
  logic [23:0] data_addr;
  logic [7:0]  wr_data, p0_latch, p2_latch, op_data, lo_in, lo_out, lo_oe, hi_out, hi_oe, drv;
  logic [7:0]  page;
  logic [7:0]  mem_e [8];
  bit          val [8];
  int          n_mismatch, n_checks, j, k, a, i;
  // Wire level: the device wins where it drives, memory elsewhere.
  assign lo_in = (lo_out & lo_oe) | (drv & ~lo_oe);
  embi_top embi_top_inst (.clk, .arst_n, .reset_pin, .pc, .fetch_req, .rd_req, .wr_req,
    .data_addr, .wr_data, .p0_latch, .p2_latch, .op_done, .op_data, .op_internal, .core_reset,
    .download_mode, .external_access_select(ea), .program_fetch_strobe_in(strap),
    .program_fetch_strobe_n(fetch_n), .addr_latch_strobe(latch_stb), .data_read_strobe_n(rd_n),
    .data_store_strobe_n(st_n), .low_byte_bus_port_in(lo_in), .low_byte_bus_port_out(lo_out),
    .low_byte_bus_port_oe(lo_oe), .high_byte_port_out(hi_out), .high_byte_port_oe(hi_oe));
  embi_mem_model embi_mem_model_inst (.clk, .latch_stb, .fetch_n, .rd_n, .st_n, .bus(lo_in),
    .hi(hi_out), .drv, .page);
  // Clock at 25 MHz.
  always #20 clk = ~clk;
  function automatic logic [7:0] exp_code(input logic [15:0] p);
    return p[7:0] ^ {p[11:8], p[15:12]};
  endfunction : exp_code
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic wrap_up;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  // Request is held for the taking edge only, so it is not taken twice.
  task automatic run(input int kind);
    fetch_req = (kind == 0);
    rd_req = (kind == 1);
    wr_req = (kind == 2);
    @(posedge clk) #1;
    {fetch_req, rd_req, wr_req} = 3'h0;
    for (i = 0; i < 12 && op_done !== 1'b1; i++) @(posedge clk) #1;
    check(8'(op_done), 8'h01);
  endtask : run
  // Hang guard well past the expected run length.
  initial begin
    #(40 * 4000);
    n_mismatch++;
    wrap_up;
  end
  initial begin
    {clk, arst_n, reset_pin, fetch_req, rd_req, wr_req, pc, data_addr, wr_data} = '0;
    {p0_latch, p2_latch, ea, strap} = {16'hFFFF, 2'h3};
    k = $urandom(32'h2670ba37);
    repeat (5) @(posedge clk);
    #1 arst_n = 1;
    @(posedge clk) #1;
    // Boundary addresses first, then random traffic.
    for (j = 0; j < 40; j++) begin
      k = (j < 4) ? 0 : $urandom_range(2);
      a = $urandom_range(7);
      ea = (j < 4) ? 1'b1 : 1'($urandom_range(1));
      pc = (j < 4) ? 16'h1FFE + 16'(j) : 16'($urandom);
      data_addr = {8'($urandom), 5'h00, 3'(a), 8'($urandom)};
      wr_data = 8'($urandom);
      p0_latch = 8'($urandom);
      p2_latch = 8'($urandom);
      run(k);
      if (k == 0) check(8'(op_internal), 8'(ea && pc <= INT_CODE_TOP));
      if (k == 0 && !(ea && pc <= INT_CODE_TOP)) check(op_data, exp_code(pc));
      if (k == 1 && val[a]) check(op_data, mem_e[a]);
      if (k != 0) check(page, data_addr[23:16]);
      if (k == 2) {mem_e[a], val[a]} = {wr_data, 1'b1};
      @(posedge clk) #1;
      check(lo_oe, ~p0_latch);
      check(lo_out & lo_oe, 8'h00);
      check(hi_oe, ~p2_latch);
      check(hi_out, p2_latch);
    end
    reset_pin = 1;
    repeat (24) @(posedge clk);
    #1 check(8'(core_reset), 8'h00);
    strap = 0;
    @(posedge clk) #1;
    check(8'(core_reset), 8'h01);
    repeat (4) @(posedge clk);
    #1 check(8'(core_reset), 8'h01);
    reset_pin = 0;
    repeat (4) @(posedge clk);
    #1 check(8'(download_mode), 8'h01);
    check(8'(core_reset), 8'h00);
    wrap_up;
  end
endmodule : tb_external_memory_bus_interface
`default_nettype wire
